/* core/tpio_params.svh */
`ifndef TPIO_PARAMS_SVH
`define TPIO_PARAMS_SVH

// register indices; byte address is four times the index
`define TPIO_IDX_LAT_A 8'h00
`define TPIO_IDX_LAT_B 8'h01
`define TPIO_IDX_LAT_C 8'h02
`define TPIO_IDX_DIR_A 8'h04
`define TPIO_IDX_DIR_B 8'h05
`define TPIO_IDX_DIR_C 8'h06
`define TPIO_IDX_OPT 8'h1d

// port widths
`define TPIO_WIDTH_A 8
`define TPIO_WIDTH_B 8
`define TPIO_WIDTH_C 5

// option register field positions
`define TPIO_OPT_PULL_A_BIT 0
`define TPIO_OPT_PULL_B_BIT 1
`define TPIO_OPT_PULL_C_BIT 2
`define TPIO_OPT_DRIVE_BIT 5

// reset values
`define TPIO_DIR_RST 8'h00
`define TPIO_PULL_RST 1'b0
`define TPIO_DRIVE_RST 1'b1

// synchroniser depth
`define TPIO_SYNC_STAGES 2

`endif

/* core/tpio_pkg.sv */
package tpio_pkg;

	typedef logic [7:0] tpio_byte_t;

	typedef enum logic [2:0]
	{
		TPIO_SEL_NONE,
		TPIO_SEL_LAT_A,
		TPIO_SEL_LAT_B,
		TPIO_SEL_LAT_C,
		TPIO_SEL_DIR_A,
		TPIO_SEL_DIR_B,
		TPIO_SEL_DIR_C,
		TPIO_SEL_OPT
	} tpio_sel_t;

endpackage : tpio_pkg

/* core/tpio_sync.sv */
`timescale 1ns/1ps
`include "tpio_params.svh"

module tpio_sync
	import tpio_pkg::*;
#(
	parameter int WIDTH = 21
)
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	// ***************************************************
	// two-stage synchroniser
	// ***************************************************
	logic [WIDTH-1:0] stage_one;

	// first stage feeds only the second stage
	always_ff @(posedge clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			stage_one <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage_one <= async_in;
			sync_out <= stage_one;
		end
	end

endmodule : tpio_sync

/* core/tpio_top.sv */
// Operation
// - eight-pin first port, per-pin direction, pullups
// - output latches kept through reset
// - direction one enables pin driver
// - reset clears first port directions
// - first port read: latch or pin
// - data writes always update latches
// - first pullup only on input pins
// - eight-pin second port, same behaviour
// - second pullup only on input pins
// - second port read: latch or pin
// - reset clears second port directions
// - five-pin third port with drive option
// - third pullup only on input pins
// - drive option selects third port drive
// - third port read: latch or pin
// - reset clears third port directions
// - direction registers read back written value
//
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
`include "tpio_params.svh"

module tpio_top
	import tpio_pkg::*;
#(
	parameter int WIDTH_A = `TPIO_WIDTH_A,
	parameter int WIDTH_B = `TPIO_WIDTH_B,
	parameter int WIDTH_C = `TPIO_WIDTH_C
)
(
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic [WIDTH_A-1:0] PORTA_IN,
	output logic [WIDTH_A-1:0] PORTA_OUT,
	output logic [WIDTH_A-1:0] PORTA_OE_N,
	output logic [WIDTH_A-1:0] PORTA_PULLUP,
	input wire logic [WIDTH_B-1:0] PORTB_IN,
	output logic [WIDTH_B-1:0] PORTB_OUT,
	output logic [WIDTH_B-1:0] PORTB_OE_N,
	output logic [WIDTH_B-1:0] PORTB_PULLUP,
	input wire logic [WIDTH_C-1:0] PORTC_IN,
	output logic [WIDTH_C-1:0] PORTC_OUT,
	output logic [WIDTH_C-1:0] PORTC_OE_N,
	output logic [WIDTH_C-1:0] PORTC_PULLUP,
	output logic [WIDTH_C-1:0] PORTC_HIGH_DRIVE
);

	localparam int PIN_TOTAL = WIDTH_A + WIDTH_B + WIDTH_C;

	// ***************************************************
	// state
	// ***************************************************
	logic [WIDTH_A-1:0] port_a_output_latch;
	logic [WIDTH_B-1:0] port_b_output_latch;
	logic [WIDTH_C-1:0] port_c_output_latch;
	logic [WIDTH_A-1:0] port_a_direction;
	logic [WIDTH_B-1:0] port_b_direction;
	logic [WIDTH_C-1:0] port_c_direction;
	logic first_port_pullup_enable;
	logic second_port_pullup_enable;
	logic third_port_pullup_enable;
	logic indicator_drive_option;

	logic [PIN_TOTAL-1:0] pins_sync;
	logic [WIDTH_A-1:0] pin_level_a;
	logic [WIDTH_B-1:0] pin_level_b;
	logic [WIDTH_C-1:0] pin_level_c;

	tpio_sel_t sel;
	logic setup_phase;
	logic wr_strobe;
	logic [9:0] word_index;
	logic [31:0] next_rdata;
	logic next_slverr;
	tpio_byte_t opt_image;

	// ***************************************************
	// pin synchronisation
	// ***************************************************
	// synchronise all pins
	tpio_sync #(
		.WIDTH(PIN_TOTAL)
	) u_pin_sync (
		.clk(CLK_SYS),
		.arst_n(ARST_N),
		.async_in({PORTC_IN, PORTB_IN, PORTA_IN}),
		.sync_out(pins_sync)
	);

	assign pin_level_a = pins_sync[WIDTH_A-1:0];
	assign pin_level_b = pins_sync[WIDTH_A+WIDTH_B-1:WIDTH_A];
	assign pin_level_c = pins_sync[PIN_TOTAL-1:WIDTH_A+WIDTH_B];

	// ***************************************************
	// bus decode
	// ***************************************************
	assign word_index = PADDR[11:2];
	assign setup_phase = PSEL && !PENABLE;
	assign wr_strobe = PSEL && PENABLE && PWRITE;

	always_comb
	begin
		if (PADDR[1:0] != 2'h0 || word_index[9:8] != 2'h0)
		begin
			sel = TPIO_SEL_NONE;
		end
		else
		begin
			case (word_index[7:0])
				`TPIO_IDX_LAT_A: sel = TPIO_SEL_LAT_A;
				`TPIO_IDX_LAT_B: sel = TPIO_SEL_LAT_B;
				`TPIO_IDX_LAT_C: sel = TPIO_SEL_LAT_C;
				`TPIO_IDX_DIR_A: sel = TPIO_SEL_DIR_A;
				`TPIO_IDX_DIR_B: sel = TPIO_SEL_DIR_B;
				`TPIO_IDX_DIR_C: sel = TPIO_SEL_DIR_C;
				`TPIO_IDX_OPT: sel = TPIO_SEL_OPT;
				default: sel = TPIO_SEL_NONE;
			endcase
		end
	end

	// zero-wait slave: every access phase completes at once
	assign PREADY = 1'b1;

	// ***************************************************
	// output latches
	// ***************************************************
	// no reset term: contents survive reset
	always_ff @(posedge CLK_SYS)
	begin
		if (wr_strobe && sel == TPIO_SEL_LAT_A)
		begin
			port_a_output_latch <= PWDATA[WIDTH_A-1:0];
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (wr_strobe && sel == TPIO_SEL_LAT_B)
		begin
			port_b_output_latch <= PWDATA[WIDTH_B-1:0];
		end
	end

	always_ff @(posedge CLK_SYS)
	begin
		if (wr_strobe && sel == TPIO_SEL_LAT_C)
		begin
			port_c_output_latch <= PWDATA[WIDTH_C-1:0];
		end
	end

	// ***************************************************
	// direction registers
	// ***************************************************
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			port_a_direction <= WIDTH_A'(`TPIO_DIR_RST);
		end
		else if (wr_strobe && sel == TPIO_SEL_DIR_A)
		begin
			port_a_direction <= PWDATA[WIDTH_A-1:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			port_b_direction <= WIDTH_B'(`TPIO_DIR_RST);
		end
		else if (wr_strobe && sel == TPIO_SEL_DIR_B)
		begin
			port_b_direction <= PWDATA[WIDTH_B-1:0];
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			port_c_direction <= WIDTH_C'(`TPIO_DIR_RST);
		end
		else if (wr_strobe && sel == TPIO_SEL_DIR_C)
		begin
			port_c_direction <= PWDATA[WIDTH_C-1:0];
		end
	end

	// ***************************************************
	// option register
	// ***************************************************
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			first_port_pullup_enable <= `TPIO_PULL_RST;
			second_port_pullup_enable <= `TPIO_PULL_RST;
			third_port_pullup_enable <= `TPIO_PULL_RST;
			indicator_drive_option <= `TPIO_DRIVE_RST;
		end
		else if (wr_strobe && sel == TPIO_SEL_OPT)
		begin
			first_port_pullup_enable <= PWDATA[`TPIO_OPT_PULL_A_BIT];
			second_port_pullup_enable <= PWDATA[`TPIO_OPT_PULL_B_BIT];
			third_port_pullup_enable <= PWDATA[`TPIO_OPT_PULL_C_BIT];
			indicator_drive_option <= PWDATA[`TPIO_OPT_DRIVE_BIT];
		end
	end

	// unimplemented option bits read as zero
	always_comb
	begin
		opt_image = 8'h00;
		opt_image[`TPIO_OPT_PULL_A_BIT] = first_port_pullup_enable;
		opt_image[`TPIO_OPT_PULL_B_BIT] = second_port_pullup_enable;
		opt_image[`TPIO_OPT_PULL_C_BIT] = third_port_pullup_enable;
		opt_image[`TPIO_OPT_DRIVE_BIT] = indicator_drive_option;
	end

	// ***************************************************
	// pin drive
	// ***************************************************
	// first port pins
	genvar gi;
	generate
		for (gi = 0; gi < WIDTH_A; gi++)
		begin : g_port_a
			assign PORTA_OUT[gi] = port_a_output_latch[gi];
			// driver on when direction is one
			assign PORTA_OE_N[gi] = !port_a_direction[gi];
			assign PORTA_PULLUP[gi] = first_port_pullup_enable && !port_a_direction[gi];
		end
	endgenerate

	generate
		for (gi = 0; gi < WIDTH_B; gi++)
		begin : g_port_b
			assign PORTB_OUT[gi] = port_b_output_latch[gi];
			// driver on when direction is one
			assign PORTB_OE_N[gi] = !port_b_direction[gi];
			assign PORTB_PULLUP[gi] = second_port_pullup_enable && !port_b_direction[gi];
		end
	endgenerate

	generate
		for (gi = 0; gi < WIDTH_C; gi++)
		begin : g_port_c
			assign PORTC_OUT[gi] = port_c_output_latch[gi];
			// driver on when direction is one
			assign PORTC_OE_N[gi] = !port_c_direction[gi];
			assign PORTC_PULLUP[gi] = third_port_pullup_enable && !port_c_direction[gi];
			assign PORTC_HIGH_DRIVE[gi] = indicator_drive_option && port_c_direction[gi];
		end
	endgenerate

	// ***************************************************
	// read path
	// ***************************************************
	always_comb
	begin
		next_rdata = 32'h0000_0000;
		next_slverr = 1'b0;
		case (sel)
			// latch for outputs, pin for inputs
			TPIO_SEL_LAT_A:
			begin
				next_rdata[WIDTH_A-1:0] = (port_a_output_latch & port_a_direction)
					| (pin_level_a & ~port_a_direction);
			end
			// latch for outputs, pin for inputs
			TPIO_SEL_LAT_B:
			begin
				next_rdata[WIDTH_B-1:0] = (port_b_output_latch & port_b_direction)
					| (pin_level_b & ~port_b_direction);
			end
			// latch for outputs, pin for inputs
			TPIO_SEL_LAT_C:
			begin
				next_rdata[WIDTH_C-1:0] = (port_c_output_latch & port_c_direction)
					| (pin_level_c & ~port_c_direction);
			end
			TPIO_SEL_DIR_A:
			begin
				next_rdata[WIDTH_A-1:0] = port_a_direction;
			end
			TPIO_SEL_DIR_B:
			begin
				next_rdata[WIDTH_B-1:0] = port_b_direction;
			end
			TPIO_SEL_DIR_C:
			begin
				next_rdata[WIDTH_C-1:0] = port_c_direction;
			end
			TPIO_SEL_OPT:
			begin
				next_rdata[7:0] = opt_image;
			end
			default:
			begin
				next_slverr = 1'b1;
			end
		endcase
	end

	// read data and error captured in the setup cycle
	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			PRDATA <= 32'h0000_0000;
		end
		else if (setup_phase)
		begin
			PRDATA <= PWRITE ? 32'h0000_0000 : next_rdata;
		end
	end

	always_ff @(posedge CLK_SYS or negedge ARST_N)
	begin
		if (!ARST_N)
		begin
			PSLVERR <= 1'b0;
		end
		else if (setup_phase)
		begin
			PSLVERR <= next_slverr;
		end
	end

endmodule : tpio_top

/* sim/tpio_top_asserts.sv */
`timescale 1ns/1ps
module tpio_top_asserts
	import tpio_pkg::*;
#(
	parameter int WIDTH_A = 8,
	parameter int WIDTH_B = 8,
	parameter int WIDTH_C = 5
)
(
	input wire logic CLK_SYS,
	input wire logic ARST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	input wire logic [WIDTH_A-1:0] PORTA_IN,
	input wire logic [WIDTH_A-1:0] PORTA_OUT,
	input wire logic [WIDTH_A-1:0] PORTA_OE_N,
	input wire logic [WIDTH_A-1:0] PORTA_PULLUP,
	input wire logic [WIDTH_B-1:0] PORTB_IN,
	input wire logic [WIDTH_B-1:0] PORTB_OUT,
	input wire logic [WIDTH_B-1:0] PORTB_OE_N,
	input wire logic [WIDTH_B-1:0] PORTB_PULLUP,
	input wire logic [WIDTH_C-1:0] PORTC_IN,
	input wire logic [WIDTH_C-1:0] PORTC_OUT,
	input wire logic [WIDTH_C-1:0] PORTC_OE_N,
	input wire logic [WIDTH_C-1:0] PORTC_PULLUP,
	input wire logic [WIDTH_C-1:0] PORTC_HIGH_DRIVE
);
	// ********
	// pin and register checks
	// ********
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!ARST_N);
	chk_pull_a_input: assert property (!(|(PORTA_PULLUP & ~PORTA_OE_N)))
		else $error("pullup on output pin a");
	chk_pull_b_input: assert property (!(|(PORTB_PULLUP & ~PORTB_OE_N)))
		else $error("pullup on output pin b");
	chk_pull_c_input: assert property (!(|(PORTC_PULLUP & ~PORTC_OE_N)))
		else $error("pullup on output pin c");
	chk_drive_c_out: assert property (!(|(PORTC_HIGH_DRIVE & PORTC_OE_N)))
		else $error("high drive on input pin c");
	chk_reset_dirs: assert property ($rose(ARST_N) |-> &{PORTA_OE_N, PORTB_OE_N, PORTC_OE_N})
		else $error("pin driven after reset");
	chk_reset_pulls: assert property ($rose(ARST_N) |-> !(|{PORTA_PULLUP, PORTB_PULLUP, PORTC_PULLUP}))
		else $error("pullup on after reset");
	chk_dir_a_write: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h010
		|=> PORTA_OE_N == ~$past(PWDATA[WIDTH_A-1:0])) else $error("dir a write lost");
	chk_lat_b_write: assert property (PSEL && PENABLE && PWRITE && PADDR == 12'h004
		|=> PORTB_OUT == $past(PWDATA[WIDTH_B-1:0])) else $error("latch b write lost");
	chk_dir_c_read: assert property (PSEL && !PENABLE && !PWRITE && PADDR == 12'h018
		|=> PRDATA == {{(32-WIDTH_C){1'b0}}, ~$past(PORTC_OE_N)}) else $error("dir c read bad");
	chk_unmapped_err: assert property (PSEL && PENABLE && PADDR == 12'h00c |-> PSLVERR)
		else $error("no error on unmapped");
	cover property (PSEL && PENABLE && PWRITE && PADDR == 12'h074);
	cover property (PSEL && PENABLE && PSLVERR);
	cover property (PSEL && PENABLE && PADDR[1:0] != 2'h0 && PSLVERR);
	cover property ($rose(ARST_N));
endmodule : tpio_top_asserts

bind tpio_top tpio_top_asserts #(.WIDTH_A(WIDTH_A), .WIDTH_B(WIDTH_B), .WIDTH_C(WIDTH_C)) u_chk (.*);

/* sim/tpio_board.sv */
`timescale 1ns/1ps
module tpio_board
#(
	parameter int W = 8
)
(
	input wire logic clk,
	input wire logic [W-1:0] pin_out,
	input wire logic [W-1:0] oe_n,
	input wire logic [W-1:0] pull,
	input wire logic [W-1:0] drv_val,
	input wire logic [W-1:0] drv_en,
	output logic [W-1:0] pin
);
	// ********
	// pin level
	// ********
	logic [W-1:0] last = '0;
	// driver wins, pullup only if released
	always_comb pin = (~oe_n & pin_out) | (oe_n & drv_en & drv_val) | (oe_n & ~drv_en & (pull | ~last));
	// floating pin wanders every cycle
	always_ff @(posedge clk) last <= pin;
endmodule : tpio_board

/* sim/tpio_top_tb.sv */
`timescale 1ns/1ps
`include "tpio_params.svh"
module tpio_top_tb
	import tpio_pkg::*;
;
	// ********
	// bench
	// ********
	logic clk_sys = 1'b0;
	logic arst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready, pslverr;
	logic [7:0] pin_a, out_a, oen_a, pul_a, pin_b, out_b, oen_b, pul_b;
	logic [4:0] pin_c, out_c, oen_c, pul_c, hdr_c;
	tpio_byte_t drv_val [3];
	tpio_byte_t drv_en [3];
	tpio_byte_t oen [3], outv [3], pulv [3];
	localparam tpio_byte_t lat_idx [3] = '{`TPIO_IDX_LAT_A, `TPIO_IDX_LAT_B, `TPIO_IDX_LAT_C};
	localparam tpio_byte_t dir_idx [3] = '{`TPIO_IDX_DIR_A, `TPIO_IDX_DIR_B, `TPIO_IDX_DIR_C};
	int fail_count = 0;
	int n_tests = 0;
	assign oen = '{oen_a, oen_b, {3'b0, oen_c}};
	assign outv = '{out_a, out_b, {3'b0, out_c}};
	assign pulv = '{pul_a, pul_b, {3'b0, pul_c}};
	always #5 clk_sys = ~clk_sys;

	tpio_top u_dut (.CLK_SYS(clk_sys), .ARST_N(arst_n), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .PORTA_IN(pin_a), .PORTA_OUT(out_a), .PORTA_OE_N(oen_a),
		.PORTA_PULLUP(pul_a), .PORTB_IN(pin_b), .PORTB_OUT(out_b), .PORTB_OE_N(oen_b),
		.PORTB_PULLUP(pul_b), .PORTC_IN(pin_c), .PORTC_OUT(out_c), .PORTC_OE_N(oen_c),
		.PORTC_PULLUP(pul_c), .PORTC_HIGH_DRIVE(hdr_c));
	tpio_board #(.W(8)) u_brd_a (.clk(clk_sys), .pin_out(out_a), .oe_n(oen_a), .pull(pul_a),
		.drv_val(drv_val[0]), .drv_en(drv_en[0]), .pin(pin_a));
	tpio_board #(.W(8)) u_brd_b (.clk(clk_sys), .pin_out(out_b), .oe_n(oen_b), .pull(pul_b),
		.drv_val(drv_val[1]), .drv_en(drv_en[1]), .pin(pin_b));
	tpio_board #(.W(5)) u_brd_c (.clk(clk_sys), .pin_out(out_c), .oe_n(oen_c), .pull(pul_c),
		.drv_val(drv_val[2][4:0]), .drv_en(drv_en[2][4:0]), .pin(pin_c));

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			fail_count++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic e,
		output logic [31:0] r);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do
			@(posedge clk_sys);
		while (pready !== 1'b1);
		r = prdata;
		chk({31'b0, pslverr}, {31'b0, e});
	endtask : xfer

	task wr(input tpio_byte_t i, input logic [31:0] d);
		logic [31:0] r;
		xfer(1'b1, {2'b00, i, 2'b00}, d, 1'b0, r);
	endtask : wr

	task rd(input tpio_byte_t i, input logic [31:0] exp, input logic e = 1'b0);
		logic [31:0] r;
		xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, e, r);
		chk(r, exp);
	endtask : rd

	task idle(input int n);
		psel <= 1'b0;
		penable <= 1'b0;
		repeat (n) @(posedge clk_sys);
	endtask : idle

	task print_verdict;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : print_verdict

	initial
	begin
		tpio_byte_t wm;
		logic [31:0] rr;
		drv_val = '{default: 8'h3c};
		drv_en = '{default: 8'hff};
		repeat (2) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		chk({oen_a, oen_b, oen_c}, 32'h1fffff);
		chk({pul_a, pul_b, pul_c, hdr_c}, 32'h0);
		rd(`TPIO_IDX_OPT, 32'h20);
		for (int p = 0; p < 3; p++)
		begin
			wm = (p == 2) ? 8'h1f : 8'hff;
			rd(dir_idx[p], 32'h0);
			wr(lat_idx[p], 32'ha5);
			idle(4);
			rd(lat_idx[p], {24'h0, 8'h3c & wm});
			drv_en[p] <= 8'hf0;
			wr(dir_idx[p], 32'h0f);
			idle(4);
			chk(outv[p], 8'ha5 & wm);
			chk(oen[p], 8'hf0 & wm);
			rd(lat_idx[p], {24'h0, 8'h35 & wm});
			rd(dir_idx[p], {24'h0, 8'h0f & wm});
		end
		chk(hdr_c, 32'h0f);
		drv_en <= '{default: 8'h00};
		wr(`TPIO_IDX_OPT, 32'h07);
		idle(4);
		chk(hdr_c, 32'h0);
		// misaligned write and out-of-range read are refused; latch a must stay a5
		xfer(1'b1, 12'h001, 32'h0, 1'b1, rr);
		xfer(1'b0, 12'h400, 32'h0, 1'b1, rr);
		chk(rr, 32'h0);
		for (int p = 0; p < 3; p++)
		begin
			wm = (p == 2) ? 8'h1f : 8'hff;
			chk(pulv[p], 8'hf0 & wm);
			rd(lat_idx[p], {24'h0, 8'hf5 & wm});
		end
		rd(`TPIO_IDX_OPT, 32'h07);
		rd(8'h03, 32'h0, 1'b1);
		arst_n <= 1'b0;
		idle(2);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		chk({oen_a, oen_b, oen_c}, 32'h1fffff);
		chk({out_a, out_b, out_c}, {11'h0, 8'ha5, 8'ha5, 5'h05});
		chk({pul_a, pul_b, pul_c}, 32'h0);
		rd(`TPIO_IDX_OPT, 32'h20);
		idle(1);
		print_verdict();
	end

	initial
	begin
		repeat (2000) @(posedge clk_sys);
		fail_count++;
		print_verdict();
	end
endmodule : tpio_top_tb
